// ===== rtl/tscr_map.vh
`ifndef TSCR_MAP_VH
`define TSCR_MAP_VH
// Status register numbers
`define TSCR_TILE_CONTROL 8'h02
`define TSCR_BOOT_STATUS 8'h03
`define TSCR_SECURITY 8'h05
`define TSCR_RING_CONTROL 8'h06
`define TSCR_RING_TILE_CELL 8'h07
`define TSCR_RING_TILE_WIRE 8'h08
`define TSCR_RING_PERIPH_CELL 8'h09
`define TSCR_RING_PERIPH_WIRE 8'h0a
`define TSCR_RAM_SIZE 8'h0c
`define TSCR_DEBUG_STATUS 8'h10
// Tile control fields
`define TSCR_TXDLY_HI 25
`define TSCR_TXDLY_LO 18
`define TSCR_TXDIV_HI 17
`define TSCR_TXDIV_LO 9
`define TSCR_RGMII_EN 8
`define TSCR_LP_DYNAMIC 5
`define TSCR_LP_ENABLE 4
`define TSCR_UTMI_SEL 2
`define TSCR_ULPI_EN 1
`define TSCR_CTRL_WMASK 32'h03ffff36
`define TSCR_CTRL_RESET 32'h00000000
// Security fields
`define TSCR_SEC_WLOCK 31
`define TSCR_SEC_GDBG_DIS 14
`define TSCR_SEC_LOCK_ALL 12
`define TSCR_SEC_LOCK_HI 11
`define TSCR_SEC_LOCK_LO 8
`define TSCR_SEC_OTP_RED 7
`define TSCR_SEC_OTP_BOOT 5
`define TSCR_SEC_JCFG_DIS 4
`define TSCR_SEC_TAP_DIS 0
`define TSCR_SEC_WMASK 32'h80005ff1
`define TSCR_SEC_RESET 32'h00000000
// Ring oscillator control fields
`define TSCR_RING_CORE_EN 1
`define TSCR_RING_PERIPH_EN 0
// Debug saved status word
`define TSCR_DSS_WMASK 32'h000006df
`define TSCR_DSS_RESET 32'h00000000
// RAM size in bytes, bits 1:0 read as zero
`define TSCR_RAM_BYTES 32'h00080000
// Low-power divider ratio in core cycles
`define TSCR_LP_DIV 4'h8
`endif

// ===== rtl/tscr_regs.v
`timescale 1ns/10ps
`include "tscr_map.vh"

// Functional notes
// [R1] Tile control 25:18 holds TX data delay
// [R2] TX clock high at divider, low at half
// [R3] Software writes divide ratio minus one
// [R4] Tile control bit 8 enables RGMII ports
// [R5] Bit 4 enables low-power clock divider
// [R6] Bit 5 dynamic: divide only when paused
// [R7] Bit 2 selects UTMI, clear selects ULPI
// [R8] Bit 1 enables ULPI support module
// [R9] Boot status read-only: processor number, PLL pins
// [R10] Boot status flags at bits 8,5,4,3,2
// [R11] Security bit 31 blocks further writes
// [R12] Security register loaded from OTP word
// [R13] Sector locks 11:8, lock-all at 12
// [R14] Bits 14,0,4 disable debug, TAP, config
// [R15] Bit 5 OTP boot, bit 7 redundancy
// [R16] Four ring counters, start/stop bits 1,0
// [R17] Read counters ten cycles after stopping
// [R18] Counters read as 16 bits, 0x07-0x0A
// [R19] Counter values survive system reset
// [R20] Oscillators asynchronous, usable for randomness
// [R21] RAM size register, bits 1:0 reserved
// [R22] Saved status captured on debugger entry
// [R23] Software forms resource ID from number
// [R24] Counter values synchronised before reading
module tscr_regs (
   // Clock and reset
   input wire mclk,
   input wire rst,
   // Status instruction port
   input wire psReq,
   input wire psWrite,
   input wire [7:0] psNum,
   input wire [31:0] psWrData,
   output reg psAck,
   output reg [31:0] psRdData,
   // Core state
   input wire debugMode,
   input wire debugEntry,
   input wire [31:0] threadStatus,
   input wire allPaused,
   // Boot information
   input wire [1:0] bootPllPins,
   input wire [7:0] procNumber,
   input wire bootOverride,
   input wire core1Off,
   input wire skipOtpPoll,
   input wire bootFromRam,
   input wire bootFromJtag,
   // One-time memory security word
   input wire otpSecValid,
   input wire [31:0] otpSecWord,
   // Ring oscillators
   input wire [3:0] ringOscIn,
   output reg coreRingRun,
   output reg periphRingRun,
   // RGMII transmit
   input wire [7:0] txDataIn,
   output reg [7:0] txDataOut,
   output reg txClkOut,
   output reg rgmiiPortEn,
   // Low-power clock
   output reg coreClkEn,
   // USB transceiver
   output reg usbUtmiSel,
   output reg ulpiSupportEn,
   // Security controls
   output reg globalDebugDis,
   output reg jtagTapDis,
   output reg jtagCfgDis,
   output reg otpBootOverride,
   output reg otpRedundancyEn,
   output reg [3:0] otpSectorLock
);

   function sel;
      input [7:0] num;
      input [7:0] reg_num;
      begin
         sel = (num == reg_num);
      end
   endfunction

   reg [31:0] ctrl_q;
   reg [31:0] sec_q;
   reg [1:0] ringCtl_q;
   reg [31:0] dss_q;
   reg [31:0] boot_q;
   reg [1:0] bootMeta_q;
   reg [1:0] bootSync_q;
   reg [1:0] bootWait_q;
   reg [8:0] divCnt_q;
   reg [7:0] txMem [0:255];
   reg [7:0] txWp_q;
   reg [3:0] lpCnt_q;
   reg [3:0] oscMeta_q;
   reg [3:0] oscSync_q;
   reg [3:0] oscLast_q;
   reg [15:0] ringCnt_q [0:3];
   reg [31:0] rdData_d;
   wire wrStb;
   wire [8:0] divVal;
   wire [7:0] dlyVal;
   wire [7:0] txRp;
   wire lpActive;
   wire [3:0] oscRun;

   assign wrStb = psReq & psWrite;
   assign divVal = ctrl_q[`TSCR_TXDIV_HI:`TSCR_TXDIV_LO];
   assign dlyVal = ctrl_q[`TSCR_TXDLY_HI:`TSCR_TXDLY_LO];
   assign txRp = txWp_q - dlyVal;
   assign oscRun = {ringCtl_q[`TSCR_RING_PERIPH_EN], ringCtl_q[`TSCR_RING_PERIPH_EN],
                    ringCtl_q[`TSCR_RING_CORE_EN], ringCtl_q[`TSCR_RING_CORE_EN]};

   // Tile control; reserved bits never store
   always @(posedge mclk or posedge rst)
   begin
      if (rst)
         ctrl_q <= `TSCR_CTRL_RESET; // [R1]
      else if (wrStb && sel(psNum, `TSCR_TILE_CONTROL))
         ctrl_q <= psWrData & `TSCR_CTRL_WMASK; // [R1]
   end

   // Security word: OTP load wins over a write in the same cycle
   always @(posedge mclk or posedge rst)
   begin
      if (rst)
         sec_q <= `TSCR_SEC_RESET;
      else if (otpSecValid)
         sec_q <= otpSecWord & `TSCR_SEC_WMASK; // [R12]
      else if (wrStb && sel(psNum, `TSCR_SECURITY) && !sec_q[`TSCR_SEC_WLOCK])
         sec_q <= psWrData & `TSCR_SEC_WMASK; // [R11]
   end

   // Ring oscillator start and stop
   always @(posedge mclk or posedge rst)
   begin
      if (rst)
         ringCtl_q <= 2'h0; // [R16]
      else if (wrStb && sel(psNum, `TSCR_RING_CONTROL))
         ringCtl_q <= psWrData[1:0]; // [R16]
   end

   // Saved status: capture on debugger entry beats a debugger write
   always @(posedge mclk or posedge rst)
   begin
      if (rst)
         dss_q <= `TSCR_DSS_RESET;
      else if (debugEntry)
         dss_q <= threadStatus & (`TSCR_DSS_WMASK | 32'h00000100); // [R22]
      else if (wrStb && debugMode && sel(psNum, `TSCR_DEBUG_STATUS))
         dss_q <= (psWrData & `TSCR_DSS_WMASK) | (dss_q & 32'h00000100);
   end

   // Boot pins come from outside and pass two flops first
   always @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         bootMeta_q <= 2'h0;
         bootSync_q <= 2'h0;
      end
      else
      begin
         bootMeta_q <= bootPllPins;
         bootSync_q <= bootMeta_q;
      end
   end

   // Boot status loads until the synchronised pins have arrived, then freezes
   always @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         boot_q <= 32'h00000000;
         bootWait_q <= 2'h0;
      end
      else if (bootWait_q != 2'h3)
      begin
         boot_q <= {8'h00, procNumber, 7'h00, bootOverride, 2'h0, core1Off,
                    skipOtpPoll, bootFromRam, bootFromJtag, bootSync_q}; // [R9] [R10]
         bootWait_q <= bootWait_q + 2'h1;
      end
   end

   // TX clock counter; the core clock stands in for the PLL output
   always @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         divCnt_q <= 9'h000;
         txClkOut <= 1'b0;
      end
      else
      begin
         if (divCnt_q >= divVal)
         begin
            divCnt_q <= 9'h000; // [R3]
         end
         else
         begin
            divCnt_q <= divCnt_q + 9'h001;
         end
         if (divCnt_q == divVal)
            txClkOut <= 1'b1; // [R2]
         else if (divCnt_q == (divVal >> 1))
            txClkOut <= 1'b0; // [R2]
      end
   end

   // Delay line; a delay of zero still costs the output flop
   always @(posedge mclk)
   begin
      txMem[txWp_q] <= txDataIn;
   end

   always @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         txWp_q <= 8'h00;
         txDataOut <= 8'h00;
      end
      else
      begin
         txWp_q <= txWp_q + 8'h01;
         txDataOut <= (dlyVal == 8'h00) ? txDataIn : txMem[txRp]; // [R1]
      end
   end

   // Low-power divider gives one enable in every LP_DIV cycles
   assign lpActive = ctrl_q[`TSCR_LP_ENABLE] &
                     (!ctrl_q[`TSCR_LP_DYNAMIC] | allPaused); // [R5] [R6]

   always @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         lpCnt_q <= 4'h0;
         coreClkEn <= 1'b1;
      end
      else if (lpActive)
      begin
         if (lpCnt_q >= `TSCR_LP_DIV - 4'h1)
            lpCnt_q <= 4'h0;
         else
            lpCnt_q <= lpCnt_q + 4'h1;
         coreClkEn <= (lpCnt_q == 4'h0); // [R5]
      end
      else
      begin
         lpCnt_q <= 4'h0;
         coreClkEn <= 1'b1; // [R6]
      end
   end

   // Oscillator levels are asynchronous, two flops before edge detection
   always @(posedge mclk)
   begin
      oscMeta_q <= ringOscIn; // [R20]
      oscSync_q <= oscMeta_q; // [R24]
      oscLast_q <= oscSync_q;
   end

   // Counters have no reset so that their value survives it
   genvar gi;
   generate
      for (gi = 0; gi < 4; gi = gi + 1)
      begin : gRing
         // Power-up value only; a system reset leaves the count alone
         initial
         begin
            ringCnt_q[gi] = 16'h0000;
         end

         always @(posedge mclk)
         begin
            if (oscRun[gi] && oscSync_q[gi] && !oscLast_q[gi])
               ringCnt_q[gi] <= ringCnt_q[gi] + 16'h0001; // [R16] [R19]
         end
      end
   endgenerate

   // Read mux; unlisted numbers read zero
   always @*
   begin
      rdData_d = 32'h00000000;
      case (psNum)
         `TSCR_TILE_CONTROL: rdData_d = ctrl_q;
         `TSCR_BOOT_STATUS: rdData_d = boot_q; // [R9]
         `TSCR_SECURITY: rdData_d = sec_q;
         `TSCR_RING_CONTROL: rdData_d = {30'h00000000, ringCtl_q};
         `TSCR_RING_TILE_CELL: rdData_d = {16'h0000, ringCnt_q[0]}; // [R18]
         `TSCR_RING_TILE_WIRE: rdData_d = {16'h0000, ringCnt_q[1]}; // [R18]
         `TSCR_RING_PERIPH_CELL: rdData_d = {16'h0000, ringCnt_q[2]}; // [R18]
         `TSCR_RING_PERIPH_WIRE: rdData_d = {16'h0000, ringCnt_q[3]}; // [R18]
         `TSCR_RAM_SIZE: rdData_d = `TSCR_RAM_BYTES & 32'hfffffffc; // [R21]
         `TSCR_DEBUG_STATUS: rdData_d = dss_q; // [R22]
         default: rdData_d = 32'h00000000;
      endcase
   end

   // Every request is answered one cycle later
   always @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         psAck <= 1'b0;
      end
      else
      begin
         psAck <= psReq;
      end
   end

   // Read data holds between reads so a slow reader still sees it
   always @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         psRdData <= 32'h00000000;
      end
      else if (psReq && !psWrite)
      begin
         psRdData <= rdData_d;
      end
   end

   // Control outputs are flops that follow the registers
   always @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         rgmiiPortEn <= 1'b0;
         usbUtmiSel <= 1'b0;
         ulpiSupportEn <= 1'b0;
         coreRingRun <= 1'b0;
         periphRingRun <= 1'b0;
      end
      else
      begin
         rgmiiPortEn <= ctrl_q[`TSCR_RGMII_EN]; // [R4]
         usbUtmiSel <= ctrl_q[`TSCR_UTMI_SEL]; // [R7]
         ulpiSupportEn <= ctrl_q[`TSCR_ULPI_EN]; // [R8]
         coreRingRun <= ringCtl_q[`TSCR_RING_CORE_EN]; // [R16]
         periphRingRun <= ringCtl_q[`TSCR_RING_PERIPH_EN]; // [R16]
      end
   end

   // Security outputs
   always @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         globalDebugDis <= 1'b0;
         jtagTapDis <= 1'b0;
         jtagCfgDis <= 1'b0;
         otpBootOverride <= 1'b0;
         otpRedundancyEn <= 1'b0;
         otpSectorLock <= 4'h0;
      end
      else
      begin
         globalDebugDis <= sec_q[`TSCR_SEC_GDBG_DIS]; // [R14]
         jtagTapDis <= sec_q[`TSCR_SEC_TAP_DIS]; // [R14]
         jtagCfgDis <= sec_q[`TSCR_SEC_JCFG_DIS]; // [R14]
         otpBootOverride <= sec_q[`TSCR_SEC_OTP_BOOT]; // [R15]
         otpRedundancyEn <= sec_q[`TSCR_SEC_OTP_RED]; // [R15]
         otpSectorLock <= sec_q[`TSCR_SEC_LOCK_HI:`TSCR_SEC_LOCK_LO] |
                          {4{sec_q[`TSCR_SEC_LOCK_ALL]}}; // [R13]
      end
   end

endmodule // tscr_regs

// ===== sim/tscr_regs_assertions.sv
`timescale 1ns/10ps
module tscr_regs_assertions (
   // Clock and reset
   input wire mclk,
   input wire rst,
   // Status port
   input wire psReq,
   input wire psWrite,
   input wire [7:0] psNum,
   input wire [31:0] psWrData,
   input wire [31:0] psRdData,
   // Control outputs
   input wire rgmiiPortEn,
   input wire usbUtmiSel,
   input wire ulpiSupportEn,
   input wire coreRingRun
);
   wire wrCtrl = psReq && psWrite && psNum == 8'h02;
   wire wrRing = psReq && psWrite && psNum == 8'h06;
   wire rdReq = psReq && !psWrite;
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (rst);
   a_rgmii_follows: assert property (wrCtrl |=> ##1 rgmiiPortEn == $past(psWrData[8], 2))
      else $error("rgmii enable does not follow write");
   a_rgmii_holds: assert property ($changed(rgmiiPortEn) |-> $past(wrCtrl, 2))
      else $error("rgmii enable moved without write");
   a_utmi_follows: assert property (wrCtrl |=> ##1 usbUtmiSel == $past(psWrData[2], 2))
      else $error("utmi select does not follow write");
   a_ulpi_follows: assert property (wrCtrl |=> ##1 ulpiSupportEn == $past(psWrData[1], 2))
      else $error("ulpi enable does not follow write");
   a_ring_run: assert property (wrRing |=> ##1 coreRingRun == $past(psWrData[1], 2))
      else $error("core ring run does not follow write");
   a_ram_size: assert property (rdReq && psNum == 8'h0c |=> psRdData == 32'h00080000)
      else $error("ram size read wrong");
   a_ring_upper: assert property (rdReq && psNum >= 8'h07 && psNum <= 8'h0a |=> psRdData[31:16] == 16'h0)
      else $error("ring count upper bits set");
   a_boot_rsvd: assert property (rdReq && psNum == 8'h03 |=> psRdData[31:24] == 8'h0 && psRdData[15:9] == 7'h0 && psRdData[7:6] == 2'h0)
      else $error("boot status reserved bits set");
endmodule // tscr_regs_assertions

bind tscr_regs tscr_regs_assertions chk (.mclk, .rst, .psReq, .psWrite, .psNum, .psWrData,
   .psRdData, .rgmiiPortEn, .usbUtmiSel, .ulpiSupportEn, .coreRingRun);

// ===== sim/tscr_core_model.sv
`timescale 1ns/10ps
module tscr_core_model (
   // Clock
   input wire mclk,
   // Status instruction port
   output reg psReq,
   output reg psWrite,
   output reg [7:0] psNum,
   output reg [31:0] psWrData,
   input wire psAck,
   input wire [31:0] psRdData
);
   reg [15:0] resId;
   initial
   begin
      {psReq, psWrite, psNum, psWrData} = '0;
   end
   // One word per request; released lines show the inverse so stale data never matches
   task xfer(input w, input [7:0] n, input [31:0] wd, output [31:0] rd, output a);
   begin
      resId = {n, 8'h0c};
      @(posedge mclk);
      #1;
      psReq = 1'b1;
      psWrite = w;
      psNum = resId[15:8];
      psWrData = wd;
      @(posedge mclk);
      #1;
      psReq = 1'b0;
      psNum = ~psNum;
      psWrData = ~wd;
      rd = psRdData;
      a = psAck;
   end
   endtask
endmodule // tscr_core_model

// ===== sim/tscr_regs_bench.sv
`timescale 1ns/10ps
module tscr_regs_bench;
   reg mclk, rst, debugMode, debugEntry, allPaused, otpSecValid;
   reg bootOverride, core1Off, skipOtpPoll, bootFromRam, bootFromJtag;
   reg [1:0] bootPllPins;
   reg [7:0] procNumber, txDataIn;
   reg [31:0] threadStatus, otpSecWord, d;
   reg [3:0] ringOscIn;
   wire psReq, psWrite, psAck, coreRingRun, periphRingRun, txClkOut, rgmiiPortEn, coreClkEn;
   wire usbUtmiSel, ulpiSupportEn, globalDebugDis, jtagTapDis, jtagCfgDis;
   wire otpBootOverride, otpRedundancyEn;
   wire [3:0] otpSectorLock;
   wire [7:0] psNum, txDataOut;
   wire [31:0] psWrData, psRdData;
   int errors, checkCount, cyc, c, i;
   time t0, t1, t2;
   reg [15:0] p [7:10];
   tscr_regs dut (.*);
   tscr_core_model core (.mclk, .psReq, .psWrite, .psNum, .psWrData, .psAck, .psRdData);
   initial
   begin
      mclk = 1'b0;
      forever #2 mclk = ~mclk;
   end
   // Oscillators slower than two core cycles per level so the synchroniser sees each edge
   always #9 ringOscIn = ~ringOscIn;
   // Whole run is about 300 cycles
   always @(posedge mclk)
   begin
      cyc = cyc + 1;
      if (cyc == 6000)
      begin
         errors = errors + 1;
         end_of_test;
      end
   end
   task chk(input [31:0] seen, input [31:0] exp, input string nm);
   begin
      checkCount = checkCount + 1;
      if (seen !== exp)
      begin
         $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
         errors = errors + 1;
      end
   end
   endtask
   task rd(input [7:0] n);
      reg a;
   begin
      core.xfer(1'b0, n, 32'h0, d, a);
      chk(a, 1, "ack");
   end
   endtask
   task wr(input [7:0] n, input [31:0] v);
      reg a;
   begin
      core.xfer(1'b1, n, v, d, a);
      chk(a, 1, "write ack");
   end
   endtask
   task rdchk(input [7:0] n, input [31:0] e, input string nm);
   begin
      rd(n);
      chk(d, e, nm);
   end
   endtask
   task t_reset;
   begin
      rdchk(8'h02, 32'h0, "ctrl reset");
      rdchk(8'h06, 32'h0, "ring reset");
      rdchk(8'h04, 32'h0, "unmapped");
      wr(8'h03, 32'hffffffff);
      rdchk(8'h03, 32'h00a5012b, "boot status");
      $display("test reset done");
   end
   endtask
   task t_ctrl;
   begin
      wr(8'h02, 32'hffffffcf);
      rdchk(8'h02, 32'h03ffff06, "ctrl mask");
      chk({rgmiiPortEn, usbUtmiSel, ulpiSupportEn}, 3'h7, "ctrl on");
      wr(8'h02, 32'h0);
      rdchk(8'h02, 32'h0, "ctrl clear");
      chk({rgmiiPortEn, usbUtmiSel, ulpiSupportEn}, 3'h0, "ctrl off");
      $display("test ctrl done");
   end
   endtask
   task t_tx;
   begin
      wr(8'h02, 32'h00080600);
      @(posedge txClkOut) t0 = $time;
      @(posedge txClkOut) t1 = $time;
      @(negedge txClkOut) t2 = $time;
      chk((t1 - t0) / 4, 4, "tx period");
      chk((t2 - t1) / 4, 2, "tx high");
      @(posedge mclk);
      #1 txDataIn = 8'h5a;
      c = 0;
      while (txDataOut !== 8'h5a && c < 10)
      begin
         @(posedge mclk);
         #1 c = c + 1;
      end
      chk(c, 3, "tx delay");
      wr(8'h02, 32'h0);
      $display("test tx done");
   end
   endtask
   task cnt_en;
   begin
      c = 0;
      repeat (2) @(posedge mclk);
      repeat (16) @(posedge mclk) #1 if (coreClkEn === 1'b1) c = c + 1;
   end
   endtask
   task t_lp;
   begin
      wr(8'h02, 32'h10);
      cnt_en;
      chk(c, 2, "static divide");
      wr(8'h02, 32'h30);
      cnt_en;
      chk(c, 16, "dynamic running");
      allPaused = 1'b1;
      cnt_en;
      chk(c, 2, "dynamic paused");
      wr(8'h02, 32'h0);
      cnt_en;
      chk(c, 16, "divider off");
      allPaused = 1'b0;
      $display("test low power done");
   end
   endtask
   task t_sec;
   begin
      @(posedge mclk);
      #1 otpSecWord = 32'h000051b1;
      otpSecValid = 1'b1;
      @(posedge mclk);
      #1 otpSecValid = 1'b0;
      rdchk(8'h05, 32'h000051b1, "otp copy");
      chk({globalDebugDis, jtagTapDis, jtagCfgDis, otpBootOverride, otpRedundancyEn}, 5'h1f, "sec on");
      chk(otpSectorLock, 4'hf, "lock all");
      wr(8'h05, 32'h00000200);
      rdchk(8'h05, 32'h00000200, "sec write");
      chk({globalDebugDis, jtagTapDis, jtagCfgDis, otpBootOverride, otpRedundancyEn}, 5'h0, "sec off");
      chk(otpSectorLock, 4'h2, "sector lock");
      wr(8'h05, 32'h80000000);
      wr(8'h05, 32'h0);
      rdchk(8'h05, 32'h80000000, "sec locked");
      $display("test security done");
   end
   endtask
   task t_dbg;
   begin
      threadStatus = 32'hffffffff;
      @(posedge mclk);
      #1 debugEntry = 1'b1;
      @(posedge mclk);
      #1 debugEntry = 1'b0;
      rdchk(8'h10, 32'h000007df, "capture");
      wr(8'h10, 32'h0);
      rdchk(8'h10, 32'h000007df, "dss guarded");
      debugMode = 1'b1;
      wr(8'h10, 32'h0);
      rdchk(8'h10, 32'h00000100, "dss write");
      debugMode = 1'b0;
      $display("test debug done");
   end
   endtask
   task ring_run;
   begin
      wr(8'h06, 32'h3);
      repeat (50) @(posedge mclk);
      chk({coreRingRun, periphRingRun}, 2'h3, "ring run on");
      wr(8'h06, 32'h0);
      repeat (10) @(posedge mclk);
      chk({coreRingRun, periphRingRun}, 2'h0, "ring run off");
   end
   endtask
   task t_ring;
   begin
      ring_run;
      for (i = 7; i <= 10; i++)
      begin
         rd(i);
         p[i] = d[15:0];
      end
      ring_run;
      for (i = 7; i <= 10; i++)
      begin
         rd(i);
         c = d[15:0] - p[i];
         chk(c >= 9 && c <= 14, 1, "ring counted");
         p[i] = d[15:0];
      end
      {procNumber, bootOverride, core1Off, skipOtpPoll, bootFromRam, bootFromJtag, bootPllPins} = 15'h1e16;
      rst = 1'b1;
      repeat (2) @(posedge mclk);
      #1 rst = 1'b0;
      rdchk(8'h07, {16'h0, p[7]}, "ring kept");
      rdchk(8'h0a, {16'h0, p[10]}, "ring kept");
      rdchk(8'h03, 32'h003c0016, "boot status");
      $display("test ring done");
   end
   endtask
   task end_of_test;
   begin
      $display("checks %0d mismatches %0d", checkCount, errors);
      if (errors == 0 && checkCount > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   end
   endtask
   initial
   begin
      {errors, checkCount, cyc} = '0;
      {debugMode, debugEntry, allPaused, otpSecValid, txDataIn, threadStatus, otpSecWord} = '0;
      ringOscIn = 4'h0;
      {procNumber, bootOverride, core1Off, skipOtpPoll, bootFromRam, bootFromJtag, bootPllPins} = 15'h52eb;
      rst = 1'b1;
      repeat (6) @(posedge mclk);
      #1 rst = 1'b0;
      t_reset;
      t_ctrl;
      t_tx;
      t_lp;
      t_sec;
      t_dbg;
      t_ring;
      end_of_test;
   end
endmodule // tscr_regs_bench
